// >>> iorm_io_register_map.v
`timescale 1ns/1ps
// Overview of operation
// - writing one to an interrupt flag clears it and writing zero leaves it alone.
// - a bit set or clear access rewrites the whole register, so flags read set get cleared.
// - bit set and clear accesses work only at addresses up to 1F, others need byte access.
// - the timer count register is a full byte, all eight bits read and written by the core.
`include "iorm_defs.vh"
module iorm_io_register_map (
   input  wire       core_clk,
   input  wire       rst_n,
   input  wire [5:0] io_addr,
   input  wire       io_rd,
   input  wire       io_wr,
   input  wire [7:0] io_wdata,
   input  wire       io_bit_set,
   input  wire       io_bit_clr,
   input  wire [2:0] io_bit_sel,
   output reg  [7:0] io_rdata,
   input  wire [5:0] pin_in,
   input  wire       cmp_out,
   input  wire       ev_cmp,
   input  wire       ev_tov,
   input  wire       ev_ext,
   input  wire       ev_pc,
   input  wire       ev_wdr,
   input  wire       ev_bor,
   input  wire       ev_extr,
   input  wire       ev_por,
   input  wire       tcnt_inc,
   input  wire       cpu_status_flags_ld,
   input  wire [7:0] cpu_status_flags_in,
   output reg  [7:0] cmp_ctl,
   output reg  [7:0] port_dir,
   output reg  [7:0] port_out,
   output reg  [7:0] nvm_ctl,
   output reg  [7:0] nvm_dat,
   output reg  [7:0] nvm_adr,
   output reg  [7:0] wdt_ctl,
   output reg  [7:0] osc_trim,
   output reg  [7:0] tcnt,
   output reg  [7:0] tclk_sel,
   output reg  [7:0] rst_cause,
   output reg  [7:0] sleep_ctl,
   output reg  [7:0] tirq_flg,
   output reg  [7:0] tirq_msk,
   output reg  [7:0] girq_flg,
   output reg  [7:0] girq_msk,
   output reg  [7:0] cpu_status_flags
);

   // limitation: holes read zero, so software cannot detect a missing
   // register other than by its value; writes there are silently dropped

   // release goes through two flops so no register leaves reset on a ragged edge
   reg  [1:0] rst_sync_q;
   wire       rst_l_n = rst_sync_q[1];
   reg  [5:0] pin_s1_q;
   reg  [5:0] pin_s2_q;
   reg        cmp_s1_q;
   reg        cmp_s2_q;

   // reads of the current value, zero for holes and unused bits
   function [7:0] rd_mux;
      input [5:0] a;
      begin
         case (a)
            `IORM_A_CMP:   rd_mux = (cmp_ctl & ~8'h20) | {2'b00, cmp_s2_q, 5'b0_0000};
            `IORM_A_PIN:   rd_mux = {2'b00, pin_s2_q};
            `IORM_A_DIR:   rd_mux = port_dir;
            `IORM_A_OUT:   rd_mux = port_out;
            `IORM_A_NVMC:  rd_mux = nvm_ctl;
            `IORM_A_NVMD:  rd_mux = nvm_dat;
            `IORM_A_NVMA:  rd_mux = nvm_adr;
            `IORM_A_WDT:   rd_mux = wdt_ctl;
            `IORM_A_OSC:   rd_mux = osc_trim;
            `IORM_A_TCNT:  rd_mux = tcnt;
            `IORM_A_TCS:   rd_mux = tclk_sel;
            `IORM_A_RSTC:  rd_mux = rst_cause;
            `IORM_A_SLP:   rd_mux = sleep_ctl;
            `IORM_A_TIMER_IRQ_FLAGS:  rd_mux = tirq_flg;
            `IORM_A_TIMER_IRQ_MASK: rd_mux = tirq_msk;
            `IORM_A_GENERAL_IRQ_FLAGS:  rd_mux = girq_flg;
            `IORM_A_GENERAL_IRQ_MASK: rd_mux = girq_msk;
            `IORM_A_CPU_STATUS_FLAGS:  rd_mux = cpu_status_flags;
            default:       rd_mux = 8'h00;
         endcase
      end
   endfunction

   // bit accesses only in the low range; above it they are dropped
   wire       bit_ok = (io_bit_set | io_bit_clr) && (io_addr <= `IORM_BIT_TOP);
   wire [7:0] bit_m  = 8'h01 << io_bit_sel;
   wire [7:0] cur    = rd_mux(io_addr);
   // read-modify-write: the full read value goes back, flags included
   wire [7:0] bit_v  = io_bit_set ? (cur | bit_m) : (cur & ~bit_m);
   // a byte write in the same cycle outranks a bit strobe
   wire       we     = io_wr | bit_ok;
   wire [7:0] wv     = io_wr ? io_wdata : bit_v;

   // hardware set vectors for the flag registers
   wire [7:0] cmp_set = {3'b000, ev_cmp, 4'h0};
   wire [7:0] tov_set = {6'h00, ev_tov, 1'b0};
   wire [7:0] gif_set = {1'b0, ev_ext, ev_pc, 5'h00};
   wire [7:0] rsc_set = {4'h0, ev_wdr, ev_bor, ev_extr, ev_por};

   function wsel;
      input [5:0] a;
      input [5:0] r;
      begin
         wsel = we && (a == r);
      end
   endfunction

   // flag update: hardware set wins over a one-write clear
   // so an event landing in the clearing cycle is never lost
   function [7:0] w1c;
      input [7:0] q;
      input       w;
      input [7:0] d;
      input [7:0] m;
      input [7:0] s;
      begin
         w1c = ((q & ~(w ? d : 8'h00)) | s) & m;
      end
   endfunction

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   // pins are asynchronous to the core clock
   always @(posedge core_clk or negedge rst_l_n) begin
      if (!rst_l_n) begin
         pin_s1_q <= 6'h00;
         pin_s2_q <= 6'h00;
         cmp_s1_q <= 1'b0;
         cmp_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= pin_in;
         pin_s2_q <= pin_s1_q;
         cmp_s1_q <= cmp_out;
         cmp_s2_q <= cmp_s1_q;
      end
   end

   always @(posedge core_clk or negedge rst_l_n) begin
      if (!rst_l_n) begin
         io_rdata  <= `IORM_RST_VAL;
         cmp_ctl   <= `IORM_RST_VAL;
         port_dir  <= `IORM_RST_VAL;
         port_out  <= `IORM_RST_VAL;
         nvm_ctl   <= `IORM_RST_VAL;
         nvm_dat   <= `IORM_RST_VAL;
         nvm_adr   <= `IORM_RST_VAL;
         wdt_ctl   <= `IORM_RST_VAL;
         osc_trim  <= `IORM_RST_VAL;
         tcnt      <= `IORM_RST_VAL;
         tclk_sel  <= `IORM_RST_VAL;
         rst_cause <= `IORM_RST_VAL;
         sleep_ctl <= `IORM_RST_VAL;
         tirq_flg  <= `IORM_RST_VAL;
         tirq_msk  <= `IORM_RST_VAL;
         girq_flg  <= `IORM_RST_VAL;
         girq_msk  <= `IORM_RST_VAL;
         cpu_status_flags      <= `IORM_RST_VAL;
      end else begin
         // idle read bus parks at zero, a stray sample cannot look valid
         io_rdata <= io_rd ? cur : 8'h00;
         // comparator: control bits plain, interrupt flag one-to-clear
         // output bit 5 is live from the pin, never stored
         cmp_ctl <= (wsel(io_addr, `IORM_A_CMP) ? (wv & `IORM_M_CMP_W) : (cmp_ctl & `IORM_M_CMP_W))
                  | w1c(cmp_ctl, wsel(io_addr, `IORM_A_CMP), wv, `IORM_M_CMP_FLG,
                        cmp_set);
         if (wsel(io_addr, `IORM_A_DIR))
            port_dir <= wv & `IORM_M_DIR;
         if (wsel(io_addr, `IORM_A_OUT))
            port_out <= wv & `IORM_M_OUT;
         if (wsel(io_addr, `IORM_A_NVMC))
            nvm_ctl <= wv & `IORM_M_NVMC;
         if (wsel(io_addr, `IORM_A_NVMD))
            nvm_dat <= wv;
         if (wsel(io_addr, `IORM_A_NVMA))
            nvm_adr <= wv & `IORM_M_NVMA;
         if (wsel(io_addr, `IORM_A_WDT))
            wdt_ctl <= wv & `IORM_M_WDT;
         if (wsel(io_addr, `IORM_A_OSC))
            osc_trim <= wv;
         // core write outranks a counting tick in the same cycle
         if (wsel(io_addr, `IORM_A_TCNT))
            tcnt <= wv;
         else if (tcnt_inc)
            tcnt <= tcnt + 8'h01;
         if (wsel(io_addr, `IORM_A_TCS))
            tclk_sel <= wv & `IORM_M_TCS;
         // reset cause: software may clear by writing zero, events set
         rst_cause <= ((wsel(io_addr, `IORM_A_RSTC) ? wv : rst_cause)
                      | rsc_set) & `IORM_M_RSTC;
         if (wsel(io_addr, `IORM_A_SLP))
            sleep_ctl <= wv & `IORM_M_SLP;
         tirq_flg <= w1c(tirq_flg, wsel(io_addr, `IORM_A_TIMER_IRQ_FLAGS), wv, `IORM_M_TIMER_IRQ_FLAGS,
                         tov_set);
         if (wsel(io_addr, `IORM_A_TIMER_IRQ_MASK))
            tirq_msk <= wv & `IORM_M_TIMER_IRQ_MASK;
         girq_flg <= w1c(girq_flg, wsel(io_addr, `IORM_A_GENERAL_IRQ_FLAGS), wv, `IORM_M_GENERAL_IRQ_FLAGS,
                         gif_set);
         if (wsel(io_addr, `IORM_A_GENERAL_IRQ_MASK))
            girq_msk <= wv & `IORM_M_GENERAL_IRQ_MASK;
         // core flag updates yield to an explicit register write
         if (wsel(io_addr, `IORM_A_CPU_STATUS_FLAGS))
            cpu_status_flags <= wv;
         else if (cpu_status_flags_ld)
            cpu_status_flags <= cpu_status_flags_in;
      end
   end

endmodule

// >>> iorm_defs.vh
`ifndef IORM_DEFS_VH
`define IORM_DEFS_VH
// register addresses
`define IORM_A_CMP     6'h08
`define IORM_A_PIN     6'h16
`define IORM_A_DIR     6'h17
`define IORM_A_OUT     6'h18
`define IORM_A_NVMC    6'h1C
`define IORM_A_NVMD    6'h1D
`define IORM_A_NVMA    6'h1E
`define IORM_A_WDT     6'h21
`define IORM_A_OSC     6'h31
`define IORM_A_TCNT    6'h32
`define IORM_A_TCS     6'h33
`define IORM_A_RSTC    6'h34
`define IORM_A_SLP     6'h35
`define IORM_A_TIMER_IRQ_FLAGS    6'h38
`define IORM_A_TIMER_IRQ_MASK   6'h39
`define IORM_A_GENERAL_IRQ_FLAGS    6'h3A
`define IORM_A_GENERAL_IRQ_MASK   6'h3B
`define IORM_A_CPU_STATUS_FLAGS    6'h3F
// highest address reachable by single-bit access
`define IORM_BIT_TOP   6'h1F
// implemented-bit masks
`define IORM_M_CMP     8'hDB
`define IORM_M_CMP_W   8'hCB
`define IORM_M_CMP_FLG 8'h10
`define IORM_M_PIN     8'h3F
`define IORM_M_DIR     8'h3F
`define IORM_M_OUT     8'h1F
`define IORM_M_NVMC    8'h0F
`define IORM_M_NVMA    8'h3F
`define IORM_M_WDT     8'h1F
`define IORM_M_TCS     8'h07
`define IORM_M_RSTC    8'h0F
`define IORM_M_SLP     8'h73
`define IORM_M_TIMER_IRQ_FLAGS    8'h02
`define IORM_M_TIMER_IRQ_MASK   8'h02
`define IORM_M_GENERAL_IRQ_FLAGS    8'h60
`define IORM_M_GENERAL_IRQ_MASK   8'h60
// reset value of every register
`define IORM_RST_VAL   8'h00
`endif

// >>> iorm_checker.sv
`timescale 1ns/1ps
module iorm_checker (
   input wire       core_clk,
   input wire       rst_n,
   input wire [5:0] io_addr,
   input wire       io_rd,
   input wire       io_wr,
   input wire [7:0] io_wdata,
   input wire       io_bit_set,
   input wire       io_bit_clr,
   input wire [2:0] io_bit_sel,
   input wire       ev_tov,
   input wire       ev_cmp,
   input wire [7:0] io_rdata,
   input wire [7:0] tirq_flg,
   input wire [7:0] cmp_ctl,
   input wire [7:0] tcnt,
   input wire [7:0] tirq_msk,
   input wire [7:0] port_dir
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_bit_hi;
      (io_bit_set || io_bit_clr) && !io_wr && io_addr > 6'h1F;
   endsequence
   sequence s_set(a);
      io_bit_set && !io_wr && io_addr == a;
   endsequence
   sequence s_wr_timer_irq_flags;
      io_wr && io_addr == 6'h38;
   endsequence
   chk_w1c_clear: assert property (
      s_wr_timer_irq_flags ##0 io_wdata[1] && !ev_tov |=> !tirq_flg[1]) else $error("flag not cleared");
   chk_w1c_keep: assert property (
      s_wr_timer_irq_flags ##0 !io_wdata[1] && tirq_flg[1] |=> tirq_flg[1]) else $error("flag lost");
   chk_bit_rmw: assert property (
      s_set(6'h08) ##0 !ev_cmp |=> !cmp_ctl[4]) else $error("flag kept by bit set");
   chk_bit_high: assert property (
      s_bit_hi |=> $stable(tirq_msk)) else $error("bit access above range");
   chk_bit_low: assert property (
      s_set(6'h17) ##0 io_bit_sel < 3'h6 |=> port_dir[$past(io_bit_sel)])
      else $error("bit set lost");
   chk_tcnt_byte: assert property (
      io_wr && io_addr == 6'h32 |=> tcnt == $past(io_wdata)) else $error("count not full byte");
   chk_hole_read: assert property (
      io_rd && io_addr == 6'h3E |=> io_rdata == 8'h00) else $error("hole read not zero");
   chk_rd_idle: assert property (
      !io_rd |=> io_rdata == 8'h00) else $error("read data without read");
endmodule

// >>> iorm_core_model.sv
`timescale 1ns/1ps
module iorm_core_model (
   input  wire       core_clk,
   input  wire [7:0] io_rdata,
   output reg  [5:0] io_addr    = 6'h00,
   output reg        io_rd      = 1'b0,
   output reg        io_wr      = 1'b0,
   output reg  [7:0] io_wdata   = 8'h00,
   output reg        io_bit_set = 1'b0,
   output reg        io_bit_clr = 1'b0,
   output reg  [2:0] io_bit_sel = 3'h0
);
   // k: 0 read, 1 write, 2 bit set, 3 bit clear; d[2:0] is the bit index
   // callers give zeros in unused bits holes written only to probe refusal
   task go(input [1:0] k, input [5:0] a, input [7:0] d, output [7:0] q);
      begin
         @(negedge core_clk);
         io_addr = a;
         io_wdata = d;
         io_bit_sel = d[2:0];
         {io_rd, io_wr, io_bit_set, io_bit_clr} = 4'h8 >> k;
         @(negedge core_clk);
         q = io_rdata;
         {io_rd, io_wr, io_bit_set, io_bit_clr} = 4'h0;
         // released data must not look valid
         io_wdata = ~d;
      end
   endtask
endmodule

// >>> iorm_io_register_map_tb.sv
`timescale 1ns/1ps
module iorm_io_register_map_tb;
   reg        core_clk  = 1'b0;
   reg        rst_n     = 1'b0;
   reg  [5:0] pin_in    = 6'h00;
   reg  [9:0] ev        = 10'h000;
   reg  [7:0] cpu_status_flags_in   = 8'h00;
   reg  [7:0] q;
   reg        cmp_out   = 1'b0;
   wire [7:0] port_out, nvm_ctl, nvm_dat, nvm_adr, wdt_ctl, osc_trim;
   wire [7:0] tclk_sel, sleep_ctl, girq_msk, cmp_ctl;
   integer    error_cnt = 0;
   integer    cmp_count = 0;
   wire [5:0] io_addr;
   wire [7:0] io_wdata, io_rdata, port_dir, tirq_msk;
   wire [2:0] io_bit_sel;
   wire       io_rd, io_wr, io_bit_set, io_bit_clr;
   always #20 core_clk = ~core_clk;
   iorm_core_model core_u (.core_clk(core_clk), .io_rdata(io_rdata), .io_addr(io_addr),
      .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_bit_set(io_bit_set),
      .io_bit_clr(io_bit_clr), .io_bit_sel(io_bit_sel));
   iorm_io_register_map dut_u (.core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr),
      .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_bit_set(io_bit_set),
      .io_bit_clr(io_bit_clr), .io_bit_sel(io_bit_sel), .io_rdata(io_rdata),
      .pin_in(pin_in), .cmp_out(cmp_out), .ev_cmp(ev[0]), .ev_tov(ev[1]), .ev_ext(ev[2]),
      .ev_pc(ev[3]), .ev_wdr(ev[4]), .ev_bor(ev[5]), .ev_extr(ev[6]), .ev_por(ev[7]),
      .tcnt_inc(ev[8]), .cpu_status_flags_ld(ev[9]), .cpu_status_flags_in(cpu_status_flags_in), .cmp_ctl(cmp_ctl),
      .port_dir(port_dir), .port_out(port_out), .nvm_ctl(nvm_ctl), .nvm_dat(nvm_dat),
      .nvm_adr(nvm_adr), .wdt_ctl(wdt_ctl), .osc_trim(osc_trim), .tcnt(),
      .tclk_sel(tclk_sel), .rst_cause(), .sleep_ctl(sleep_ctl), .tirq_flg(),
      .tirq_msk(tirq_msk), .girq_flg(), .girq_msk(girq_msk), .cpu_status_flags());
   task check(input [7:0] s, input [7:0] e);
      begin
         cmp_count = cmp_count + 1;
         if (s !== e) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t saw %h want %h", $time, s, e);
         end
      end
   endtask
   task rc(input [5:0] a, input [7:0] e);
      begin
         core_u.go(2'd0, a, 8'h00, q);
         check(q, e);
      end
   endtask
   task wr_rd(input [5:0] a, input [7:0] v);
      begin
         core_u.go(2'd1, a, v, q);
         rc(a, v);
      end
   endtask
   // only implemented bits are written, unused ones stay zero
   task rw_sweep;
      begin
         wr_rd(6'h18, 8'h1F);
         wr_rd(6'h1C, 8'h0F);
         wr_rd(6'h1D, 8'hFF);
         wr_rd(6'h1E, 8'h3F);
         wr_rd(6'h21, 8'h1F);
         wr_rd(6'h31, 8'hFF);
         wr_rd(6'h33, 8'h07);
         wr_rd(6'h35, 8'h73);
         wr_rd(6'h3B, 8'h60);
         wr_rd(6'h08, 8'hCB);
         wr_rd(6'h34, 8'h00);
         check(port_out, 8'h1F);
         check(nvm_ctl, 8'h0F);
         check(nvm_dat, 8'hFF);
         check(nvm_adr, 8'h3F);
         check(wdt_ctl, 8'h1F);
         check(osc_trim, 8'hFF);
         check(tclk_sel, 8'h07);
         check(sleep_ctl, 8'h73);
         check(girq_msk, 8'h60);
         check(cmp_ctl, 8'hCB);
         cmp_out = 1'b1;
         repeat (3) @(negedge core_clk);
         rc(6'h08, 8'hEB);
         $display("register sweep done");
      end
   endtask
   task mid_reset;
      begin
         @(negedge core_clk);
         rst_n = 1'b0;
         repeat (2) @(negedge core_clk);
         rst_n = 1'b1;
         repeat (4) @(negedge core_clk);
         check(port_out, 8'h00);
         check(cmp_ctl, 8'h00);
         rc(6'h1D, 8'h00);
         $display("mid-run reset done");
      end
   endtask
   task pulse(input [9:0] e);
      begin
         @(negedge core_clk);
         ev = e;
         @(negedge core_clk);
         ev = 10'h000;
      end
   endtask
   task end_sim;
      begin
         $display("compares %0d mismatches %0d", cmp_count, error_cnt);
         if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      #100000;
      error_cnt = error_cnt + 1;
      end_sim;
   end
   initial begin
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      rc(6'h3F, 8'h00);
      core_u.go(2'd1, 6'h3E, 8'hFF, q);
      rc(6'h3E, 8'h00);
      rc(6'h00, 8'h00);
      $display("reset and holes done");
      core_u.go(2'd1, 6'h32, 8'hFF, q);
      rc(6'h32, 8'hFF);
      pulse(10'h100);
      rc(6'h32, 8'h00);
      cpu_status_flags_in = 8'hA5;
      pulse(10'h200);
      rc(6'h3F, 8'hA5);
      $display("timer and status done");
      pulse(10'h0FF);
      rc(6'h34, 8'h0F);
      rc(6'h08, 8'h10);
      core_u.go(2'd1, 6'h3A, 8'h40, q);
      rc(6'h3A, 8'h20);
      core_u.go(2'd1, 6'h38, 8'h00, q);
      rc(6'h38, 8'h02);
      core_u.go(2'd1, 6'h38, 8'h02, q);
      rc(6'h38, 8'h00);
      $display("flags done");
      pin_in = 6'h2A;
      core_u.go(2'd2, 6'h08, 8'h00, q);
      rc(6'h08, 8'h01);
      core_u.go(2'd2, 6'h39, 8'h01, q);
      check(tirq_msk, 8'h00);
      core_u.go(2'd2, 6'h17, 8'h05, q);
      check(port_dir, 8'h20);
      core_u.go(2'd3, 6'h17, 8'h05, q);
      rc(6'h17, 8'h00);
      rc(6'h16, 8'h2A);
      $display("bit access done");
      rw_sweep;
      mid_reset;
      end_sim;
   end
endmodule
bind iorm_io_register_map iorm_checker chk_u (.core_clk(core_clk), .rst_n(rst_n),
   .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
   .io_bit_set(io_bit_set), .io_bit_clr(io_bit_clr), .io_bit_sel(io_bit_sel),
   .ev_tov(ev_tov), .ev_cmp(ev_cmp), .io_rdata(io_rdata), .tirq_flg(tirq_flg),
   .cmp_ctl(cmp_ctl), .tcnt(tcnt), .tirq_msk(tirq_msk), .port_dir(port_dir));
